//--- core/phy_mgmt_consts.vh
// Constants for the two-port PHY management register bank.
// Assumes inclusion by bare name from the core design files.
`ifndef PHY_MGMT_CONSTS_VH
`define PHY_MGMT_CONSTS_VH

// Management register addresses seen on the serial management pins
`define REG_CTRL         5'h00
`define REG_STAT         5'h01
`define REG_ID_HI        5'h02
`define REG_ID_LO        5'h03
`define REG_ADV          5'h04
`define REG_LPA          5'h05
`define REG_DIAG         5'h1D
`define REG_SPEC         5'h1F

// Basic control bit positions
`define CB_LOOP          14
`define CB_F100          13
`define CB_ANEN          12
`define CB_PDN           11
`define CB_ANRS          9
`define CB_FDX           8
`define CB_XSTY          5
`define CB_FMDI          4
`define CB_NOMDIX        3
`define CB_NOFEF         2
`define CB_TXDIS         1
`define CB_LEDDIS        0

// Basic status fixed capability bits and live bit positions
`define SB_CAPS          16'h7800
`define SB_ANDONE        5
`define SB_FEF           4
`define SB_ANABLE        3
`define SB_LINK          2

// Identifier values (arbitrary, neutral)
`define ID_HI_VAL        16'hA5A5
`define ID_LO_VAL        16'h5A50

// Switch-side register map, port 2 sits one stride above port 1
`define SW_GCTL          8'h0F
`define SW_R28           8'h1C
`define SW_R29           8'h1D
`define SW_R30           8'h1E
`define SW_R31           8'h1F
`define SW_STRIDE        8'h10
`define SW_PHYAD_MSB     7
`define SW_PHYAD_LSB     3
`define SW_GCTL_RST      8'h08

// Switch-side bit positions
`define SW_ANEN          7
`define SW_F100          6
`define SW_FDX           5
`define SW_LOOP          0
`define SW_FMDI          1
`define SW_NOMDIX        2
`define SW_PDN           3
`define SW_NOFEF         4
`define SW_ANRS          5
`define SW_TXDIS         6
`define SW_LEDDIS        7
`define SW_ANDONE        6
`define SW_LINK          5
`define SW_XSTY          7
`define SW_FEF           0

// Management frame layout
`define PRE_LEN          6'h20
`define HDR_LEN          6'h0D
`define WR_LEN           6'h12
`define DATA_LEN         6'h10
`define OP_RD            2'h2
`define OP_WR            2'h1
`define PHY2_OFS         5'h01

`endif

//--- core/mgmt_pin_sync.v
// Two-flop synchronisers for the management clock and data pins,
// with edge detection on the clean management clock.
// Assumes pins are asynchronous to i_clk and much slower than it.
`timescale 1ns/1ps
module mgmt_pin_sync (
  input  wire i_clk,
  input  wire i_rst_b,
  input  wire i_ce,
  input  wire i_mdc,
  input  wire i_mdio,
  output wire o_mdc_rise,
  output wire o_mdc_fall,
  output wire o_mdio
);

  reg [1:0] mdc_meta;
  reg [1:0] mdio_meta;
  reg       mdc_last;

  // Edge detector looks only at the second stage
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      mdc_meta  <= 2'h0;
      mdio_meta <= 2'h3;
      mdc_last  <= 1'b0;
    end else if (i_ce) begin
      mdc_meta  <= {mdc_meta[0], i_mdc};
      mdio_meta <= {mdio_meta[0], i_mdio};
      mdc_last  <= mdc_meta[1];
    end
  end

  assign o_mdc_rise = i_ce & mdc_meta[1] & ~mdc_last;
  assign o_mdc_fall = i_ce & ~mdc_meta[1] & mdc_last;
  assign o_mdio     = mdio_meta[1];

endmodule

//--- core/phy_mgmt_register_bank.v
// Management register bank for two PHY ports, reached over MDC/MDIO,
// with a switch-side byte port sharing the same storage.
// Assumes PHY status inputs and switch port are on i_clk; pins are not.
// Contract
// - After reset PHY1 answers address 1 and PHY2 address 2.
// - Global register 15 bits 7:3 reprogram the PHY address.
// - Only registers 0-3 are decoded; 4, 5, 1D, 1F and all others read 0.
// - Switch-side map reaches the same bits as the PHY view, except port 2 control bit 2.
// - Control bit 14 enables far-end loopback, resets to 0.
// - Loopback bit shares storage with switch reg 29/45 bit 0.
// - Control bit 12 enables autonegotiation, resets 1, alias 28/44 b7.
// - Writing 1 to bit 9 restarts autonegotiation; reads as 0.
// - Control bit 5 selects crossover style, resets 1, alias 31/47 b7.
// - Control bit 4 forces MDI, resets to 0.
// - Control bit 3 disables auto crossover, resets to 0.
// - Control bit 2 disables far-end fault; aliased port 1 only.
// - Control bit 1 disables transmitter, alias 29/45 bit 6.
// - Status bits 14-11 read 1, bit 15 reads 0.
// - Status bit 0 and reserved bits 10-7 read 0.
// - Status bit 5 shows autonegotiation done, mirrors 30/46 bit 6.
// - Status bit 4 shows far-end fault, mirrors reg 31 bit 0.
// - Status bit 3 shows autonegotiation ability from 28/44 bit 7.
`timescale 1ns/1ps
module phy_mgmt_register_bank (
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire       i_ce,
  input  wire       i_mdc,
  input  wire       i_mdio,
  output reg        o_mdio,
  output reg        o_mdio_oe,
  input  wire       i_sw_wr,
  input  wire       i_sw_rd,
  input  wire [7:0] i_sw_addr,
  input  wire [7:0] i_sw_wdata,
  output reg  [7:0] o_sw_rdata,
  input  wire [1:0] i_link_up,
  input  wire [1:0] i_an_done,
  input  wire       i_far_fault,
  output wire [1:0] o_loopback,
  output wire [1:0] o_force_100,
  output wire [1:0] o_autoneg_enable,
  output wire [1:0] o_power_down,
  output reg  [1:0] o_autoneg_restart,
  output wire [1:0] o_force_full,
  output wire [1:0] o_crossover_style_select,
  output wire [1:0] o_force_mdi,
  output wire [1:0] o_mdix_disable,
  output wire [1:0] o_fef_disable,
  output wire [1:0] o_tx_disable,
  output wire [1:0] o_led_disable
);

`include "phy_mgmt_consts.vh"

  localparam [2:0] S_PRE   = 3'h0;
  localparam [2:0] S_HDR   = 3'h1;
  localparam [2:0] S_WR    = 3'h2;
  localparam [2:0] S_RD_TA = 3'h3;
  localparam [2:0] S_RD    = 3'h4;

  // Shared control storage, one bit per port, plus the global control byte gctl
  reg [1:0] loop;
  reg [1:0] f100;
  reg [1:0] anen;
  reg [1:0] pdn;
  reg [1:0] fdx;
  reg [1:0] xsty;
  reg [1:0] fmdi;
  reg [1:0] nomdix;
  reg [1:0] nofef;
  reg [1:0] txdis;
  reg [1:0] leddis;
  reg [7:0] gctl;

  // Frame engine state
  reg [2:0]  state;
  reg [5:0]  cnt;
  reg [12:0] hdr;
  reg [17:0] wsh;
  reg [15:0] rsh;
  reg        ta_seen;
  reg        port;
  reg [4:0]  regad;
  reg        mdio_wr;
  wire       mdc_rise;
  wire       mdc_fall;
  wire       mdio_in;

  wire [4:0] phyad1 = gctl[`SW_PHYAD_MSB:`SW_PHYAD_LSB];
  wire [4:0] phyad2 = phyad1 + `PHY2_OFS;
  // Decoded on the last header rise, before the final shift lands:
  // start bit at 11, op at 10:9, PHY address at 8:4
  wire [4:0] hdr_pa = hdr[8:4];
  wire [1:0] hdr_op = hdr[10:9];
  wire       hit1   = (hdr_pa == phyad1);
  wire       hit2   = (hdr_pa == phyad2);

  mgmt_pin_sync u_sync (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_ce       (i_ce),
    .i_mdc      (i_mdc),
    .i_mdio     (i_mdio),
    .o_mdc_rise (mdc_rise),
    .o_mdc_fall (mdc_fall),
    .o_mdio     (mdio_in)
  );

  // Basic control word; soft reset, isolate, collision test read 0
  function [15:0] ctrl_word;
    input p;
    begin
      ctrl_word = 16'h0000;
      ctrl_word[`CB_LOOP]   = loop[p];
      ctrl_word[`CB_F100]   = f100[p];
      ctrl_word[`CB_ANEN]   = anen[p];
      ctrl_word[`CB_PDN]    = pdn[p];
      ctrl_word[`CB_FDX]    = fdx[p];
      ctrl_word[`CB_XSTY]   = xsty[p];
      ctrl_word[`CB_FMDI]   = fmdi[p];
      ctrl_word[`CB_NOMDIX] = nomdix[p];
      ctrl_word[`CB_NOFEF]  = nofef[p];
      ctrl_word[`CB_TXDIS]  = txdis[p];
      ctrl_word[`CB_LEDDIS] = leddis[p];    // Restart reads 0
    end
  endfunction

  // Basic status word; far-end fault exists on port 1 only
  function [15:0] stat_word;
    input p;
    begin
      stat_word = `SB_CAPS;
      stat_word[`SB_ANDONE] = i_an_done[p];
      stat_word[`SB_FEF]    = ~p & i_far_fault;
      stat_word[`SB_ANABLE] = anen[p];
      stat_word[`SB_LINK]   = i_link_up[p];
    end
  endfunction

  // Read mux for the management view
  function [15:0] phy_read;
    input       p;
    input [4:0] ra;
    begin
      case (ra)
        `REG_CTRL:  phy_read = ctrl_word(p);
        `REG_STAT:  phy_read = stat_word(p);
        `REG_ID_HI: phy_read = `ID_HI_VAL;
        `REG_ID_LO: phy_read = `ID_LO_VAL;
        default:    phy_read = 16'h0000;
      endcase
    end
  endfunction

  // Switch-side byte view of the same bits
  function [7:0] sw_read;
    input [7:0] a;
    reg         p;
    reg [7:0]   ra;
    begin
      sw_read = 8'h00;
      p  = (a >= `SW_R28 + `SW_STRIDE);
      ra = p ? a - `SW_STRIDE : a;
      if (a == `SW_GCTL) begin
        sw_read = gctl;
      end else if (ra == `SW_R28) begin
        sw_read[`SW_ANEN] = anen[p];
        sw_read[`SW_F100] = f100[p];
        sw_read[`SW_FDX]  = fdx[p];
      end else if (ra == `SW_R29) begin
        sw_read[`SW_LOOP]   = loop[p];
        sw_read[`SW_FMDI]   = fmdi[p];
        sw_read[`SW_NOMDIX] = nomdix[p];
        sw_read[`SW_PDN]    = pdn[p];
        sw_read[`SW_NOFEF]  = ~p & nofef[0];
        sw_read[`SW_TXDIS]  = txdis[p];
        sw_read[`SW_LEDDIS] = leddis[p];
      end else if (ra == `SW_R30) begin
        sw_read[`SW_ANDONE] = i_an_done[p];
        sw_read[`SW_LINK]   = i_link_up[p];
      end else if (ra == `SW_R31) begin
        sw_read[`SW_XSTY] = xsty[p];
        sw_read[`SW_FEF]  = ~p & i_far_fault;
      end
    end
  endfunction

  // Frame engine: sample on MDC rise, drive on MDC fall
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state     <= S_PRE;
      cnt       <= 6'h00;
      hdr       <= 13'h0000;
      wsh       <= 18'h00000;
      rsh       <= 16'h0000;
      ta_seen   <= 1'b0;
      port      <= 1'b0;
      regad     <= 5'h00;
      mdio_wr   <= 1'b0;
      o_mdio    <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else if (i_ce) begin
      mdio_wr <= 1'b0;
      case (state)
        S_PRE: begin
          // Need 32 ones, then the first start bit 0
          if (mdc_rise) begin
            if (mdio_in) begin
              if (cnt != `PRE_LEN) begin
                cnt <= cnt + 6'h01;
              end
            end else if (cnt == `PRE_LEN) begin
              cnt   <= 6'h00;
              state <= S_HDR;
            end else begin
              cnt <= 6'h00;
            end
          end
        end
        S_HDR: begin
          if (mdc_rise) begin
            hdr <= {hdr[11:0], mdio_in};
            cnt <= cnt + 6'h01;
            if (cnt == `HDR_LEN - 6'h01) begin
              cnt <= 6'h00;
              state <= S_PRE;
              // Only our two addresses get an answer
              if (hdr[11] && (hit1 || hit2)) begin
                port  <= hit2 & ~hit1;
                regad <= {hdr[3:0], mdio_in};
                if (hdr_op == `OP_RD) begin
                  rsh     <= phy_read(hit2 & ~hit1, {hdr[3:0], mdio_in});
                  ta_seen <= 1'b0;
                  state   <= S_RD_TA;
                end else if (hdr_op == `OP_WR) begin
                  state <= S_WR;
                end
              end
            end
          end
        end
        S_WR: begin
          // Two turnaround bits then sixteen data bits, MSB first
          if (mdc_rise) begin
            wsh <= {wsh[16:0], mdio_in};
            cnt <= cnt + 6'h01;
            if (cnt == `WR_LEN - 6'h01) begin
              mdio_wr <= 1'b1;
              cnt     <= 6'h00;
              state   <= S_PRE;
            end
          end
        end
        S_RD_TA: begin
          // Stay off the pin for the first turnaround bit
          if (mdc_rise) begin
            ta_seen <= 1'b1;
          end else if (mdc_fall && ta_seen) begin
            o_mdio    <= 1'b0;
            o_mdio_oe <= 1'b1;
            cnt       <= 6'h00;
            state     <= S_RD;
          end
        end
        S_RD: begin
          if (mdc_fall) begin
            if (cnt == `DATA_LEN) begin
              o_mdio_oe <= 1'b0;
              cnt       <= 6'h00;
              state     <= S_PRE;
            end else begin
              o_mdio <= rsh[15];
              rsh    <= {rsh[14:0], 1'b0};
              cnt    <= cnt + 6'h01;
            end
          end
        end
        default: begin
          o_mdio_oe <= 1'b0;
          state     <= S_PRE;
        end
      endcase
    end
  end

  // One store, two views; a management write wins a same-cycle clash
  integer p;
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      loop   <= 2'h0;
      f100   <= 2'h0;
      anen   <= 2'h3;
      pdn    <= 2'h0;
      fdx    <= 2'h0;
      xsty   <= 2'h3;
      fmdi   <= 2'h0;
      nomdix <= 2'h0;
      nofef  <= 2'h0;
      txdis  <= 2'h0;
      leddis <= 2'h0;
      gctl   <= `SW_GCTL_RST;
      o_autoneg_restart <= 2'h0;
      o_sw_rdata        <= 8'h00;
    end else if (i_ce) begin
      o_autoneg_restart <= 2'h0;
      if (i_sw_rd) begin
        o_sw_rdata <= sw_read(i_sw_addr);
      end
      if (i_sw_wr && i_sw_addr == `SW_GCTL) begin
        gctl <= i_sw_wdata;
      end
      for (p = 0; p < 2; p = p + 1) begin
        if (i_sw_wr && i_sw_addr == `SW_R28 + p * `SW_STRIDE) begin
          anen[p] <= i_sw_wdata[`SW_ANEN];
          f100[p] <= i_sw_wdata[`SW_F100];
          fdx[p]  <= i_sw_wdata[`SW_FDX];
        end
        if (i_sw_wr && i_sw_addr == `SW_R29 + p * `SW_STRIDE) begin
          loop[p]   <= i_sw_wdata[`SW_LOOP];
          fmdi[p]   <= i_sw_wdata[`SW_FMDI];
          nomdix[p] <= i_sw_wdata[`SW_NOMDIX];
          pdn[p]    <= i_sw_wdata[`SW_PDN];
          txdis[p]  <= i_sw_wdata[`SW_TXDIS];
          leddis[p] <= i_sw_wdata[`SW_LEDDIS];
          o_autoneg_restart[p] <= i_sw_wdata[`SW_ANRS];
          if (p == 0) begin
            nofef[0] <= i_sw_wdata[`SW_NOFEF];
          end
        end
        if (i_sw_wr && i_sw_addr == `SW_R31 + p * `SW_STRIDE) begin
          xsty[p] <= i_sw_wdata[`SW_XSTY];
        end
        // Only the basic control word is writable from the pins
        if (mdio_wr && port == p && regad == `REG_CTRL) begin
          loop[p]   <= wsh[`CB_LOOP];
          f100[p]   <= wsh[`CB_F100];
          anen[p]   <= wsh[`CB_ANEN];
          pdn[p]    <= wsh[`CB_PDN];
          fdx[p]    <= wsh[`CB_FDX];
          xsty[p]   <= wsh[`CB_XSTY];
          fmdi[p]   <= wsh[`CB_FMDI];
          nomdix[p] <= wsh[`CB_NOMDIX];
          nofef[p]  <= wsh[`CB_NOFEF];
          txdis[p]  <= wsh[`CB_TXDIS];
          leddis[p] <= wsh[`CB_LEDDIS];
          o_autoneg_restart[p] <= wsh[`CB_ANRS];
        end
      end
    end
  end

  // Forced speed and duplex only matter with autonegotiation off
  assign o_force_100  = f100 & ~anen;
  assign o_force_full = fdx & ~anen;

  assign o_loopback               = loop;
  assign o_autoneg_enable         = anen;
  assign o_power_down             = pdn;
  assign o_crossover_style_select = xsty;
  assign o_force_mdi              = fmdi;
  assign o_mdix_disable           = nomdix;
  assign o_fef_disable            = nofef;
  assign o_tx_disable             = txdis;
  assign o_led_disable            = leddis;

endmodule

//--- testbench/phy_mgmt_register_bank_asserts.sv
// Port checker for the PHY management register bank.
// Assumes it is bound to the bank and that i_clk is the only clock.
`timescale 1ns/1ps
module phy_mgmt_register_bank_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_ce,
  input wire logic       i_sw_wr,
  input wire logic       i_sw_rd,
  input wire logic [7:0] i_sw_addr,
  input wire logic [7:0] i_sw_wdata,
  input wire logic [7:0] o_sw_rdata,
  input wire logic       o_mdio,
  input wire logic       o_mdio_oe,
  input wire logic [1:0] o_loopback,
  input wire logic [1:0] o_autoneg_enable,
  input wire logic [1:0] o_crossover_style_select,
  input wire logic [1:0] o_force_100,
  input wire logic [1:0] o_force_full,
  input wire logic [1:0] o_autoneg_restart
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [15:0] oe_cnt;

  // Length of each read answer; 17 bits at a floor of 4 clocks each
  always @(posedge i_clk) begin
    if (!i_rst_b || !o_mdio_oe)
      oe_cnt <= 16'h0000;
    else
      oe_cnt <= oe_cnt + 16'h0001;
  end

  // Switch-side writes to the shared port control bytes
  sequence sw_wr_ctl1;
    i_ce && i_sw_wr && i_sw_addr == 8'h1D;
  endsequence
  sequence sw_wr_an1;
    i_ce && i_sw_wr && i_sw_addr == 8'h1C;
  endsequence

  reset_vals_a: assert property (disable iff (1'b0)
    !i_rst_b && i_ce |=> o_autoneg_enable == 2'b11 && o_loopback == 2'b00
      && o_crossover_style_select == 2'b11)
    else $error("reset values wrong");
  loop_alias_a: assert property (
    sw_wr_ctl1 |=> o_loopback[0] == $past(i_sw_wdata[0]))
    else $error("loopback alias not followed");
  anen_alias_a: assert property (
    sw_wr_an1 |=> o_autoneg_enable[0] == $past(i_sw_wdata[7]))
    else $error("autoneg enable alias not followed");
  restart_pulse_a: assert property (
    sw_wr_ctl1 ##0 i_sw_wdata[5] |=> o_autoneg_restart[0] ##1
      !o_autoneg_restart[0])
    else $error("restart not a single pulse");
  force_gate_a: assert property (
    (o_force_100 & o_autoneg_enable) == 2'b00
      && (o_force_full & o_autoneg_enable) == 2'b00)
    else $error("forced mode while autoneg on");
  unmapped_zero_a: assert property (
    i_ce && i_sw_rd && i_sw_addr == 8'h00 |=> o_sw_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !(i_ce && i_sw_rd) |=> $stable(o_sw_rdata))
    else $error("read data changed without read");
  turnaround_a: assert property (
    $rose(o_mdio_oe) |-> !o_mdio)
    else $error("turnaround bit not zero");
  answer_len_a: assert property (
    $fell(o_mdio_oe) |-> $past(oe_cnt) >= 16'd67)
    else $error("read answer too short");
endmodule

bind phy_mgmt_register_bank phy_mgmt_register_bank_asserts u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sw_wr(i_sw_wr),
  .i_sw_rd(i_sw_rd), .i_sw_addr(i_sw_addr), .i_sw_wdata(i_sw_wdata),
  .o_sw_rdata(o_sw_rdata), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
  .o_loopback(o_loopback), .o_autoneg_enable(o_autoneg_enable),
  .o_crossover_style_select(o_crossover_style_select),
  .o_force_100(o_force_100), .o_force_full(o_force_full),
  .o_autoneg_restart(o_autoneg_restart));

//--- testbench/mdio_station_model.sv
// Station management controller model for the management pins.
// Assumes a pull-up on the data line; the clock idles low.
`timescale 1ns/1ps
module mdio_station_model (
  output logic o_mdc,
  output logic o_mdo,
  output logic o_mdo_en,
  input  wire  i_mdio
);
  localparam int HALF = 80;

  initial begin
    o_mdc = 1'b0;
    o_mdo = 1'b1;
    o_mdo_en = 1'b0;
  end

  // One whole frame; clock stands still once the frame ends
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [63:0] bits;
    int          i;
    bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (i = 63; i >= 0; i--) begin
      // Reads hand the line over at turnaround for good
      o_mdo_en = !(op == 2'h2 && i < 18);
      o_mdo = bits[i];
      #HALF o_mdc = 1'b1;
      if (i < 16)
        rd[i] = i_mdio;
      #HALF o_mdc = 1'b0;
    end
    o_mdo_en = 1'b0;
    #(2 * HALF);
  endtask
endmodule

//--- testbench/test_phy_mgmt_register_bank.sv
// Self-checking bench for the PHY management register bank.
// Assumes the station model drives the pins at a 160 ns link clock.
`timescale 1ns/1ps
module test_phy_mgmt_register_bank;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_sw_wr = 1'b0;
  logic        i_sw_rd = 1'b0;
  logic [7:0]  i_sw_addr = 8'h00;
  logic [7:0]  i_sw_wdata = 8'h00;
  logic [1:0]  i_link_up = 2'h0;
  logic [1:0]  i_an_done = 2'h0;
  logic        i_far_fault = 1'b0;
  logic [15:0] rd;
  wire         mdc, mdo, mdo_en, o_mdio, o_mdio_oe;
  wire  [7:0]  o_sw_rdata;
  wire  [1:0]  lb, f100, anen, pdn, rs, ffull, xsty, fmdi, nomdix;
  wire  [1:0]  nofef, txdis, leddis;
  int          fails = 0;
  int          checks = 0;
  int          pulses = 0;
  // Pull-up holds the line high whenever nobody drives it
  wire mdio_line = o_mdio_oe ? o_mdio : (mdo_en ? mdo : 1'b1);

  always #2 i_clk = ~i_clk;

  phy_mgmt_register_bank dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_ce(i_ce), .i_mdc(mdc), .i_mdio(mdio_line), .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe), .i_sw_wr(i_sw_wr), .i_sw_rd(i_sw_rd),
    .i_sw_addr(i_sw_addr), .i_sw_wdata(i_sw_wdata),
    .o_sw_rdata(o_sw_rdata), .i_link_up(i_link_up),
    .i_an_done(i_an_done), .i_far_fault(i_far_fault), .o_loopback(lb),
    .o_force_100(f100), .o_autoneg_enable(anen), .o_power_down(pdn),
    .o_autoneg_restart(rs), .o_force_full(ffull),
    .o_crossover_style_select(xsty), .o_force_mdi(fmdi),
    .o_mdix_disable(nomdix), .o_fef_disable(nofef),
    .o_tx_disable(txdis), .o_led_disable(leddis));
  mdio_station_model sm (.o_mdc(mdc), .o_mdo(mdo), .o_mdo_en(mdo_en),
    .i_mdio(mdio_line));

  // Count port 1 restart pulses
  always @(posedge i_clk) begin
    if (rs[0] === 1'b1)
      pulses++;
  end

  task automatic end_of_test;
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sw_wr <= 1'b1;
    i_sw_addr <= a;
    i_sw_wdata <= d;
    @(posedge i_clk);
    i_sw_wr <= 1'b0;
  endtask

  // Masked switch-side read, data looked at one cycle after the strobe
  task automatic sw_rd(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    @(posedge i_clk);
    i_sw_rd <= 1'b1;
    i_sw_addr <= a;
    @(posedge i_clk);
    i_sw_rd <= 1'b0;
    #1 chk({8'h00, o_sw_rdata & m}, {8'h00, e});
  endtask

  task automatic mr(input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] e);
    sm.frame(2'h2, pa, ra, 16'h0000, rd);
    chk(rd, e);
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    #300000;
    fails++;
    end_of_test;
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1 chk({12'h0, anen, xsty}, 16'h000F);
    chk({4'h0, lb, fmdi, nomdix, nofef, txdis, leddis}, 16'h0);
    mr(5'h01, 5'h00, 16'h1020);
    mr(5'h02, 5'h00, 16'h1020);
    mr(5'h01, 5'h01, 16'h7808);
    mr(5'h02, 5'h06, 16'h0000);
    mr(5'h01, 5'h1E, 16'h0000);
    mr(5'h03, 5'h00, 16'hFFFF);
    sm.frame(2'h1, 5'h01, 5'h00, 16'hFFFF, rd);
    chk(16'(pulses), 16'h0001);
    mr(5'h01, 5'h00, 16'h793F);
    chk({7'h0, lb[0], pdn[0], fmdi[0], nomdix[0], nofef[0], txdis[0],
      leddis[0], f100[0], ffull[0]}, 16'h01FC);
    sw_rd(8'h1C, 8'hE0, 8'hE0);
    sw_rd(8'h1D, 8'hFF, 8'hDF);
    sw_rd(8'h1F, 8'h81, 8'h80);
    sw_wr(8'h1D, 8'h20);
    sw_wr(8'h1C, 8'h60);
    @(posedge i_clk);
    #1 chk({12'h0, f100, ffull}, 16'h0005);
    mr(5'h01, 5'h00, 16'h2120);
    @(posedge i_clk);
    i_link_up <= 2'h3;
    i_an_done <= 2'h1;
    i_far_fault <= 1'b1;
    mr(5'h01, 5'h01, 16'h7834);
    mr(5'h02, 5'h01, 16'h780C);
    sw_rd(8'h1E, 8'h60, 8'h60);
    sw_rd(8'h2E, 8'h60, 8'h20);
    sw_wr(8'h2D, 8'h21);
    @(posedge i_clk);
    #1 chk({14'h0, lb}, 16'h0002);
    mr(5'h02, 5'h00, 16'h5020);
    sw_wr(8'h0F, 8'h50);
    mr(5'h0A, 5'h00, 16'h2120);
    mr(5'h0B, 5'h00, 16'h5020);
    mr(5'h01, 5'h00, 16'hFFFF);
    sw_rd(8'h00, 8'hFF, 8'h00);
    // Clock enable low must freeze the shared store
    @(posedge i_clk);
    i_ce <= 1'b0;
    sw_wr(8'h1D, 8'h01);
    @(posedge i_clk);
    #1 chk({14'h0, lb}, 16'h0002);
    @(posedge i_clk);
    i_ce <= 1'b1;
    end_of_test;
  end
endmodule
